// ---- design/mdsr_pkg.sv ----
// Constants for the motor driver status readout bank.
// Assumes one clock MCLK at 40 MHz and a synchronous reset.
// What this block does
// - Offset 0x0a and alias 0x1a return micro-step position in bits 6..0.
// - Back-EMF register bit 6 gives measured coil, 0 X, 1 Y.
// - Back-EMF bit 5 is 0 for expected polarity, 1 otherwise.
// - Offset 0x0b and alias 0x1b hold 5-bit back-EMF value in bits 4..0.
// - Rate register 0x0c, alias 0x1c, is eight data bits, no check bit.
// - Count step pulses arriving during undervoltage or pulse-ignoring faults.
// - Missed-pulse count saturates at 127, never wraps.
// - All registers except rate carry a check bit in bit 7.
// - X drive bit 6 shows live side, 1 top, 0 bottom.
// - X drive bit 5 shows current sign, 0 positive, 1 negative.
// - X drive bits 4..0 show live X duty value.
// - Y drive register 0x0f mirrors the X drive layout.
// - Bit 6 of 0x1e flags open X coil, of 0x1f open Y coil.
// - Bits 5 and 4 of 0x1e return live step-size line levels.
// - Bits 5 and 4 of 0x1f return live run/hold and direction levels.
// - Bits 3..0 of 0x1e flag X shorts plus/minus to ground then supply.
// - Bits 3..0 of 0x1f flag Y shorts in the same order.
// - Check bit makes the count of ones in the byte odd.
// - Reading clears missed count, open flags and short flags; live fields stay.
// - Common open flag is set while any per-coil open flag is set.
package mdsr_pkg;
  localparam logic [4:0] OFF_POSITION       = 5'h0a;
  localparam logic [4:0] OFF_POSITION_ALIAS = 5'h1a;
  localparam logic [4:0] OFF_BEMF           = 5'h0b;
  localparam logic [4:0] OFF_BEMF_ALIAS     = 5'h1b;
  localparam logic [4:0] OFF_RATE           = 5'h0c;
  localparam logic [4:0] OFF_RATE_ALIAS     = 5'h1c;
  localparam logic [4:0] OFF_MISSED         = 5'h0d;
  localparam logic [4:0] OFF_MISSED_ALIAS   = 5'h1d;
  localparam logic [4:0] OFF_X_DRIVE        = 5'h0e;
  localparam logic [4:0] OFF_Y_DRIVE        = 5'h0f;
  localparam logic [4:0] OFF_X_PINS         = 5'h1e;
  localparam logic [4:0] OFF_Y_PINS         = 5'h1f;
  localparam int         POS_CHECK          = 7;
  localparam int         POS_HIGH           = 6;
  localparam int         POS_MID            = 5;
  localparam int         POS_LOW            = 4;
  localparam logic [6:0] MISSED_MAX         = 7'h7f;
  localparam logic [6:0] MISSED_RESET       = 7'h00;
  localparam logic [7:0] DATA_RESET         = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA      = 8'h00;
  localparam logic [3:0] SHORT_RESET        = 4'h0;
  localparam logic [4:0] PIN_RESET          = 5'h00;
  typedef enum {RD_IDLE, RD_ANSWER} mdsr_rd_state_t;
endpackage

// ---- design/mdsr_count_if.sv ----
// Carrier between the readout top and its missed-pulse counter.
// Assumes both ends share MCLK and the synchronous reset.
`timescale 1ns/1ps
`default_nettype none
interface mdsr_count_if (
  input wire logic clk,
  input wire logic rst
);
  logic       pulse;
  logic       blocked;
  logic       clear;
  logic [6:0] count;
  modport counter (input clk, input rst, input pulse, input blocked,
                   input clear, output count);
  modport owner (input count, output pulse, output blocked, output clear);
endinterface
`default_nettype wire

// ---- design/mdsr_miss_counter.sv ----
// Saturating counter of step pulses that the driver ignored.
// Assumes pulse is a one-cycle strobe in the MCLK domain.
`timescale 1ns/1ps
`default_nettype none
module mdsr_miss_counter (
  mdsr_count_if.counter cif
);
  logic [6:0] next_count;
  logic [6:0] base;

  // A pulse in the clearing cycle still counts: set beats clear
  always_comb begin
    base = cif.clear ? mdsr_pkg::MISSED_RESET : cif.count;
    if (cif.pulse && cif.blocked) begin
      next_count = (base == mdsr_pkg::MISSED_MAX) ? base
                   : 7'(base + 7'h01);
    end else begin
      next_count = base;
    end
  end

  always_ff @(posedge cif.clk) begin
    if (cif.rst) begin
      cif.count <= mdsr_pkg::MISSED_RESET;
    end else begin
      cif.count <= next_count;
    end
  end

  a_count_saturate: assert property (
    @(posedge cif.clk) disable iff (cif.rst)
    cif.count == mdsr_pkg::MISSED_MAX && !cif.clear |=>
      cif.count == mdsr_pkg::MISSED_MAX)
    else $error("missed count left saturation");
  a_count_step: assert property (
    @(posedge cif.clk) disable iff (cif.rst)
    cif.pulse && cif.blocked && !cif.clear &&
      cif.count != mdsr_pkg::MISSED_MAX |=>
      cif.count == 7'($past(cif.count) + 7'h01))
    else $error("missed count did not step");
  a_count_idle: assert property (
    @(posedge cif.clk) disable iff (cif.rst)
    !(cif.pulse && cif.blocked) && !cif.clear |=> $stable(cif.count))
    else $error("missed count moved without cause");
endmodule
`default_nettype wire

// ---- design/mdsr_status_bank.sv ----
// Read-only status register bank of the micro-stepping driver.
// Assumes status inputs come from logic on MCLK; pin levels are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module mdsr_status_bank (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       SRST,
  // Register read port
  input  wire logic       RD_REQ,
  input  wire logic [4:0] RD_ADDR,
  output var  logic [7:0] RD_DATA,
  output var  logic       RD_VALID,
  // Translator and back-EMF state
  input  wire logic [6:0] MICROSTEP_POSITION,
  input  wire logic       BACK_EMF_COIL_SELECT,
  input  wire logic       BACK_EMF_WRONG_POLARITY,
  input  wire logic [4:0] BACK_EMF_VALUE,
  input  wire logic [7:0] ROTATION_RATE,
  // Coil regulation state
  input  wire logic       X_DRIVE_SIDE,
  input  wire logic       X_CURRENT_POLARITY,
  input  wire logic [4:0] X_DUTY_VALUE,
  input  wire logic       Y_DRIVE_SIDE,
  input  wire logic       Y_CURRENT_POLARITY,
  input  wire logic [4:0] Y_DUTY_VALUE,
  // Fault conditions and events
  input  wire logic       UNDERVOLTAGE,
  input  wire logic       THERMAL_SHUTDOWN,
  input  wire logic       OVERCURRENT_FAULT,
  input  wire logic       STALL_FAULT,
  input  wire logic       X_COIL_BREAK_EVENT,
  input  wire logic       Y_COIL_BREAK_EVENT,
  input  wire logic [3:0] X_SHORT_EVENT,
  input  wire logic [3:0] Y_SHORT_EVENT,
  // Device pins
  input  wire logic       STEP_ADVANCE_PULSE,
  input  wire logic       STEP_SIZE_LINE_A,
  input  wire logic       STEP_SIZE_LINE_B,
  input  wire logic       RUN_HOLD_LINE,
  input  wire logic       ROTATION_SENSE_LINE,
  // Summary flag
  output var  logic       COIL_BREAK_COMMON
);
  // Pin vector order: advance, step a, step b, run/hold, direction
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic       advance_prev;
  logic       advance_edge;
  logic       step_size_line_a_level;
  logic       step_size_line_b_level;
  logic       run_hold_line_level;
  logic       rotation_sense_line_level;

  logic       x_coil_break_flag;
  logic       y_coil_break_flag;
  logic [3:0] x_short;
  logic [3:0] y_short;
  logic       next_x_break;
  logic       next_y_break;
  logic [3:0] next_x_short;
  logic [3:0] next_y_short;

  logic       clear_missed;
  logic       clear_x;
  logic       clear_y;
  logic [7:0] read_byte;
  logic [4:0] last_addr;
  mdsr_pkg::mdsr_rd_state_t rd_state;

  mdsr_count_if cnt (.clk(MCLK), .rst(SRST));

  function automatic logic [7:0] odd_byte(input logic [6:0] d);
    odd_byte = {~^d, d};
  endfunction

  // Two flops per pin; only the second is read anywhere
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pin_meta <= mdsr_pkg::PIN_RESET;
      pin_sync <= mdsr_pkg::PIN_RESET;
    end else begin
      pin_meta <= {STEP_ADVANCE_PULSE, STEP_SIZE_LINE_A, STEP_SIZE_LINE_B,
                   RUN_HOLD_LINE, ROTATION_SENSE_LINE};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      advance_prev <= 1'b0;
    end else begin
      advance_prev <= pin_sync[4];
    end
  end

  assign advance_edge              = pin_sync[4] && !advance_prev;
  assign step_size_line_a_level    = pin_sync[3];
  assign step_size_line_b_level    = pin_sync[2];
  assign run_hold_line_level       = pin_sync[1];
  assign rotation_sense_line_level = pin_sync[0];

  // Read-clear strobes, decoded from the request itself
  assign clear_missed = RD_REQ && (RD_ADDR == mdsr_pkg::OFF_MISSED ||
                        RD_ADDR == mdsr_pkg::OFF_MISSED_ALIAS);
  assign clear_x = RD_REQ && RD_ADDR == mdsr_pkg::OFF_X_PINS;
  assign clear_y = RD_REQ && RD_ADDR == mdsr_pkg::OFF_Y_PINS;

  assign cnt.pulse   = advance_edge;
  assign cnt.blocked = UNDERVOLTAGE || THERMAL_SHUTDOWN ||
                       OVERCURRENT_FAULT || STALL_FAULT;
  assign cnt.clear   = clear_missed;

  mdsr_miss_counter u_miss (.cif(cnt.counter));

  // Latched faults: an event in the clearing cycle survives the read
  always_comb begin
    next_x_break = X_COIL_BREAK_EVENT || (x_coil_break_flag && !clear_x);
    next_y_break = Y_COIL_BREAK_EVENT || (y_coil_break_flag && !clear_y);
    next_x_short = X_SHORT_EVENT | (x_short & {4{!clear_x}});
    next_y_short = Y_SHORT_EVENT | (y_short & {4{!clear_y}});
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      x_coil_break_flag <= 1'b0;
      y_coil_break_flag <= 1'b0;
    end else begin
      x_coil_break_flag <= next_x_break;
      y_coil_break_flag <= next_y_break;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      x_short <= mdsr_pkg::SHORT_RESET;
      y_short <= mdsr_pkg::SHORT_RESET;
    end else begin
      x_short <= next_x_short;
      y_short <= next_y_short;
    end
  end

  // Common flag follows the latches without clearing them
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      COIL_BREAK_COMMON <= 1'b0;
    end else begin
      COIL_BREAK_COMMON <= next_x_break || next_y_break;
    end
  end

  // Byte returned for the requested offset; unmapped offsets read zero
  always_comb begin
    if (RD_ADDR == mdsr_pkg::OFF_POSITION ||
        RD_ADDR == mdsr_pkg::OFF_POSITION_ALIAS) begin
      read_byte = odd_byte(MICROSTEP_POSITION);
    end else if (RD_ADDR == mdsr_pkg::OFF_BEMF ||
                 RD_ADDR == mdsr_pkg::OFF_BEMF_ALIAS) begin
      read_byte = odd_byte({BACK_EMF_COIL_SELECT,
                            BACK_EMF_WRONG_POLARITY,
                            BACK_EMF_VALUE});
    end else if (RD_ADDR == mdsr_pkg::OFF_RATE ||
                 RD_ADDR == mdsr_pkg::OFF_RATE_ALIAS) begin
      read_byte = ROTATION_RATE;
    end else if (RD_ADDR == mdsr_pkg::OFF_MISSED ||
                 RD_ADDR == mdsr_pkg::OFF_MISSED_ALIAS) begin
      read_byte = odd_byte(cnt.count);
    end else if (RD_ADDR == mdsr_pkg::OFF_X_DRIVE) begin
      read_byte = odd_byte({X_DRIVE_SIDE,
                            X_CURRENT_POLARITY,
                            X_DUTY_VALUE});
    end else if (RD_ADDR == mdsr_pkg::OFF_Y_DRIVE) begin
      read_byte = odd_byte({Y_DRIVE_SIDE, Y_CURRENT_POLARITY,
                            Y_DUTY_VALUE});
    end else if (RD_ADDR == mdsr_pkg::OFF_X_PINS) begin
      read_byte = odd_byte({x_coil_break_flag, step_size_line_a_level,
                            step_size_line_b_level, x_short});
    end else if (RD_ADDR == mdsr_pkg::OFF_Y_PINS) begin
      read_byte = odd_byte({y_coil_break_flag, run_hold_line_level,
                            rotation_sense_line_level, y_short});
    end else begin
      read_byte = mdsr_pkg::UNMAPPED_DATA;
    end
  end

  // Answer one cycle after the request; data holds until the next read
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rd_state <= mdsr_pkg::RD_IDLE;
    end else begin
      case (rd_state)
        mdsr_pkg::RD_IDLE: begin
          if (RD_REQ) begin
            rd_state <= mdsr_pkg::RD_ANSWER;
          end
        end
        mdsr_pkg::RD_ANSWER: begin
          if (!RD_REQ) begin
            rd_state <= mdsr_pkg::RD_IDLE;
          end
        end
        default: rd_state <= mdsr_pkg::RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_REQ;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RD_DATA   <= mdsr_pkg::DATA_RESET;
      last_addr <= mdsr_pkg::OFF_POSITION;
    end else if (RD_REQ) begin
      RD_DATA   <= read_byte;
      last_addr <= RD_ADDR;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);

  sequence s_read_x_pins;
    RD_REQ && RD_ADDR == mdsr_pkg::OFF_X_PINS;
  endsequence
  sequence s_read_y_pins;
    RD_REQ && RD_ADDR == mdsr_pkg::OFF_Y_PINS;
  endsequence
  sequence s_read_missed;
    RD_REQ && (RD_ADDR == mdsr_pkg::OFF_MISSED ||
               RD_ADDR == mdsr_pkg::OFF_MISSED_ALIAS);
  endsequence
  sequence s_read_unmapped;
    RD_REQ && RD_ADDR > mdsr_pkg::OFF_Y_DRIVE &&
      RD_ADDR < mdsr_pkg::OFF_POSITION_ALIAS;
  endsequence

  a_read_latency: assert property (RD_REQ |=> RD_VALID ##0
    (rd_state == mdsr_pkg::RD_ANSWER))
    else $error("read answer not one cycle after request");
  a_parity_odd: assert property (RD_VALID &&
    last_addr != mdsr_pkg::OFF_RATE &&
    last_addr != mdsr_pkg::OFF_RATE_ALIAS &&
    RD_DATA != mdsr_pkg::UNMAPPED_DATA |-> ^RD_DATA)
    else $error("status byte parity not odd");
  a_position_read: assert property (RD_REQ &&
    (RD_ADDR == mdsr_pkg::OFF_POSITION ||
     RD_ADDR == mdsr_pkg::OFF_POSITION_ALIAS) |=>
    RD_DATA[6:0] == $past(MICROSTEP_POSITION))
    else $error("position field wrong");
  a_bemf_read: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_BEMF_ALIAS |=>
    RD_DATA[6:0] == {$past(BACK_EMF_COIL_SELECT),
      $past(BACK_EMF_WRONG_POLARITY), $past(BACK_EMF_VALUE)})
    else $error("back-EMF field wrong");
  a_rate_whole: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_RATE |=>
    RD_DATA == $past(ROTATION_RATE))
    else $error("rate byte altered");
  a_x_drive_read: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_X_DRIVE |=>
    RD_DATA[6:0] == {$past(X_DRIVE_SIDE), $past(X_CURRENT_POLARITY),
      $past(X_DUTY_VALUE)})
    else $error("x drive register wrong");
  a_x_pins_live: assert property (s_read_x_pins |=>
    RD_DATA[5:4] == {$past(step_size_line_a_level),
      $past(step_size_line_b_level)})
    else $error("step-size levels wrong");
  a_y_pins_live: assert property (s_read_y_pins |=>
    RD_DATA[5:4] == {$past(run_hold_line_level),
      $past(rotation_sense_line_level)})
    else $error("run/hold or direction level wrong");
  a_break_hold: assert property (x_coil_break_flag && !clear_x |=>
    x_coil_break_flag [*1])
    else $error("open flag lost without read");
  a_break_clear: assert property (
    (s_read_y_pins and !Y_COIL_BREAK_EVENT) |=> !y_coil_break_flag)
    else $error("open flag not cleared by read");
  a_short_set: assert property (X_SHORT_EVENT[3] |=> x_short[3]
    ##1 (x_short[3] || $past(clear_x)))
    else $error("short flag missed event");
  a_common_flag: assert property (
    (x_coil_break_flag || y_coil_break_flag) == COIL_BREAK_COMMON)
    else $error("common open flag disagrees");
  a_missed_read: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_MISSED |=>
    RD_DATA[6:0] == $past(cnt.count))
    else $error("missed count read wrong");
  a_bemf_direct: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_BEMF |=>
    RD_DATA[6] == $past(BACK_EMF_COIL_SELECT))
    else $error("back-EMF coil bit wrong");
  a_bemf_sign: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_BEMF |=>
    RD_DATA[5] == $past(BACK_EMF_WRONG_POLARITY))
    else $error("back-EMF polarity bit wrong");
  a_rate_alias: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_RATE_ALIAS |=>
    RD_DATA == $past(ROTATION_RATE))
    else $error("rate alias byte altered");
  a_x_side_read: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_X_DRIVE |=>
    RD_DATA[6] == $past(X_DRIVE_SIDE))
    else $error("x side bit wrong");
  a_x_sign_read: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_X_DRIVE |=>
    RD_DATA[5] == $past(X_CURRENT_POLARITY))
    else $error("x sign bit wrong");
  a_x_duty_read: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_X_DRIVE |=>
    RD_DATA[4:0] == $past(X_DUTY_VALUE))
    else $error("x duty value wrong");
  a_y_drive_read: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_Y_DRIVE |=>
    RD_DATA[6:0] == {$past(Y_DRIVE_SIDE), $past(Y_CURRENT_POLARITY),
      $past(Y_DUTY_VALUE)})
    else $error("y drive register wrong");
  a_y_break_hold: assert property (y_coil_break_flag && !clear_y |=>
    y_coil_break_flag)
    else $error("y open flag lost without read");
  a_x_break_clear: assert property (
    (s_read_x_pins and !X_COIL_BREAK_EVENT) |=> !x_coil_break_flag)
    else $error("x open flag not cleared by read");
  a_break_set: assert property (X_COIL_BREAK_EVENT |=>
    x_coil_break_flag)
    else $error("x open event not latched");
  a_y_short_set: assert property (Y_SHORT_EVENT[0] |=>
    y_short[0])
    else $error("y short flag missed event");
  a_short_clear: assert property (
    (s_read_x_pins and X_SHORT_EVENT == 4'h0) |=> x_short == 4'h0)
    else $error("x short flags not cleared by read");
  a_missed_clear: assert property (
    (s_read_missed and !(cnt.pulse && cnt.blocked)) |=>
    cnt.count == mdsr_pkg::MISSED_RESET)
    else $error("missed count not cleared by read");
  a_missed_alias: assert property (RD_REQ &&
    RD_ADDR == mdsr_pkg::OFF_MISSED_ALIAS |=>
    RD_DATA[6:0] == $past(cnt.count))
    else $error("missed count alias read wrong");
  a_unmapped_zero: assert property (s_read_unmapped |=>
    RD_DATA == mdsr_pkg::UNMAPPED_DATA)
    else $error("unmapped offset not zero");
endmodule
`default_nettype wire

// ---- verif/mdsr_ctrl_model.sv ----
// Controller model that reads status bytes over the read port.
// Assumes the bank answers one MCLK edge after each request.
`timescale 1ns/1ps
`default_nettype none
module mdsr_ctrl_model (
  // Clock
  input  wire logic       clk,
  // Read port
  output var  logic       rd_req,
  output var  logic [4:0] rd_addr,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  initial begin
    rd_req  = 1'b0;
    rd_addr = 5'h00;
  end

  // One retry only; a byte that keeps failing is handed on as it is
  task automatic read_reg(input logic [4:0] a, output logic [7:0] d,
                          output logic ok);
    for (int n = 0; n < 2; n++) begin
      @(posedge clk);
      rd_req  <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      rd_req  <= 1'b0;
      // Answer stands until the next edge; take it there
      @(posedge clk);
      d  = rd_data;
      ok = rd_valid;
      if (a[3:0] == 4'hc || ^d == 1'b1) break;
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the status readout bank.
// Assumes the controller model drives the read port; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
  mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module testbench;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] din;
    logic [7:0] exp;
  } mdsr_row_t;

  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       rd_req;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       common;
  logic [6:0] pos = 7'h00;
  logic       coil = 1'b0;
  logic       wp = 1'b0;
  logic [4:0] bemf = 5'h00;
  logic [7:0] rate = 8'h00;
  logic       xs = 1'b0, xp = 1'b0, ys = 1'b0, yp = 1'b0;
  logic [4:0] xd = 5'h00, yd = 5'h00;
  logic [3:0] flt = 4'h0;
  logic       xbrk = 1'b0, ybrk = 1'b0;
  logic [3:0] xsh = 4'h0, ysh = 4'h0;
  logic       stp = 1'b0, la = 1'b0, lb = 1'b0, rh = 1'b0, dir = 1'b0;
  int         mismatches = 0;
  int         n_compared = 0;
  logic [7:0] d;
  logic       v;

  mdsr_row_t rows [19] = '{
    '{5'h0a, 8'h00, 8'h80}, '{5'h1a, 8'h55, 8'hd5}, '{5'h0a, 8'h7f, 8'h7f},
    '{5'h0b, 8'h40, 8'h40}, '{5'h1b, 8'h20, 8'h20}, '{5'h0b, 8'h13, 8'h13},
    '{5'h0c, 8'hff, 8'hff}, '{5'h1c, 8'h00, 8'h00}, '{5'h0c, 8'h01, 8'h01},
    '{5'h0e, 8'h40, 8'h40}, '{5'h0e, 8'h3f, 8'hbf}, '{5'h0f, 8'h45, 8'h45},
    '{5'h0f, 8'h21, 8'ha1}, '{5'h1e, 8'h20, 8'h20}, '{5'h1e, 8'h10, 8'h10},
    '{5'h1f, 8'h30, 8'hb0}, '{5'h1f, 8'h10, 8'h10}, '{5'h10, 8'h00, 8'h00},
    '{5'h0d, 8'h00, 8'h80}
  };

  always #12.5 mclk = ~mclk;

  mdsr_ctrl_model i_ctrl (
    .clk      (mclk),
    .rd_req   (rd_req),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .rd_valid (rd_valid)
  );

  mdsr_status_bank i_dut (
    .MCLK                    (mclk),
    .SRST                    (srst),
    .RD_REQ                  (rd_req),
    .RD_ADDR                 (rd_addr),
    .RD_DATA                 (rd_data),
    .RD_VALID                (rd_valid),
    .MICROSTEP_POSITION      (pos),
    .BACK_EMF_COIL_SELECT    (coil),
    .BACK_EMF_WRONG_POLARITY (wp),
    .BACK_EMF_VALUE          (bemf),
    .ROTATION_RATE           (rate),
    .X_DRIVE_SIDE            (xs),
    .X_CURRENT_POLARITY      (xp),
    .X_DUTY_VALUE            (xd),
    .Y_DRIVE_SIDE            (ys),
    .Y_CURRENT_POLARITY      (yp),
    .Y_DUTY_VALUE            (yd),
    .UNDERVOLTAGE            (flt[0]),
    .THERMAL_SHUTDOWN        (flt[1]),
    .OVERCURRENT_FAULT       (flt[2]),
    .STALL_FAULT             (flt[3]),
    .X_COIL_BREAK_EVENT      (xbrk),
    .Y_COIL_BREAK_EVENT      (ybrk),
    .X_SHORT_EVENT           (xsh),
    .Y_SHORT_EVENT           (ysh),
    .STEP_ADVANCE_PULSE      (stp),
    .STEP_SIZE_LINE_A        (la),
    .STEP_SIZE_LINE_B        (lb),
    .RUN_HOLD_LINE           (rh),
    .ROTATION_SENSE_LINE     (dir),
    .COIL_BREAK_COMMON       (common)
  );

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    i_ctrl.read_reg(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, exp)
  endtask

  // Pins pass a two-flop sync, so settle three edges before reading
  task automatic apply(input logic [4:0] a, input logic [7:0] din);
    @(posedge mclk);
    case (a)
      5'h0a, 5'h1a: pos <= din[6:0];
      5'h0b, 5'h1b: {coil, wp, bemf} <= din[6:0];
      5'h0c, 5'h1c: rate <= din;
      5'h0e: {xs, xp, xd} <= din[6:0];
      5'h0f: {ys, yp, yd} <= din[6:0];
      5'h1e: {la, lb} <= din[5:4];
      5'h1f: {rh, dir} <= din[5:4];
      default: ;
    endcase
    repeat (3) @(posedge mclk);
  endtask

  // Wide pulse so the synchronised edge lands well inside the fault level
  task automatic pulse();
    @(posedge mclk);
    stp <= 1'b1;
    repeat (4) @(posedge mclk);
    stp <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge mclk);
    `CHK(rd_valid, 1'b0)
    `CHK(rd_data, 8'h00)
    `CHK(common, 1'b0)
    srst <= 1'b0;
    foreach (rows[i]) begin
      apply(rows[i].addr, rows[i].din);
      rd(rows[i].addr, rows[i].exp);
    end
    pulse();
    rd(5'h0d, 8'h80);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      flt <= 4'h1 << i;
      pulse();
    end
    flt <= 4'h0;
    rd(5'h1d, 8'h04);
    rd(5'h0d, 8'h80);
    flt <= 4'h1;
    repeat (130) pulse();
    flt <= 4'h0;
    rd(5'h0d, 8'h7f);
    @(posedge mclk);
    {la, lb, rh, dir} <= 4'h0;
    {xbrk, ybrk} <= 2'b11;
    xsh <= 4'h8;
    ysh <= 4'h5;
    @(posedge mclk);
    {xbrk, ybrk} <= 2'b00;
    xsh <= 4'h0;
    ysh <= 4'h0;
    repeat (3) @(posedge mclk);
    `CHK(common, 1'b1)
    rd(5'h1e, 8'hc8);
    `CHK(common, 1'b1)
    rd(5'h1f, 8'h45);
    repeat (2) @(posedge mclk);
    `CHK(common, 1'b0)
    rd(5'h1e, 8'h80);
    rd(5'h1f, 8'h80);
    // Open event in the clearing cycle must survive the read
    fork
      rd(5'h1f, 8'h80);
      begin
        @(posedge mclk);
        ybrk <= 1'b1;
        @(posedge mclk);
        ybrk <= 1'b0;
      end
    join
    `CHK(common, 1'b1)
    rd(5'h1f, 8'h40);
    `CHK(common, 1'b0)
    // Mid-run reset drops the latches and the missed count
    xbrk <= 1'b1;
    flt  <= 4'h1;
    pulse();
    xbrk <= 1'b0;
    flt  <= 4'h0;
    `CHK(common, 1'b1)
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(rd_valid, 1'b0)
    `CHK(common, 1'b0)
    srst <= 1'b0;
    rd(5'h0d, 8'h80);
    rd(5'h1e, 8'h80);
    wrap_up();
  end
endmodule
`default_nettype wire
